// *** design/operation_mode_supply_gating.sv ***
// Purpose: operation-mode controller and supply-based gating of channels and serial interface
// Assumes: supply flags come from analog comparators, asynchronous to sys_clk_in
// Notes:   serial framing, input mapping and diagnosis live elsewhere
//
// Operation
// - with the battery at or below 3.0 V no channel is ever enabled.
// - with the logic supply undervoltage the serial registers are held in reset and serial traffic is ignored.
// - logic supply only at low-operating level with battery below operating keeps serial usable at up to 1 MHz.
// - logic supply above low-operating, or battery operating with adequate logic supply, allows up to 5 MHz.
// - battery at or below 3.0 V makes fallback unreachable under logic undervoltage, and channels stay off in it.
// - battery above 3.0 V with adequate logic supply lets serial writes switch channels.
// - logic undervoltage with battery above 3.0 V blocks serial channel control but fallback still drives pins.
// - there are four operating modes: sleep, idle, active and fallback, plus a wake state ahead of active and one ahead of fallback.
// - mode transitions depend on the low-power request pin, input pins, channel-on bits, stay-active bit, both undervoltage flags and the wake counter.
// - a turn-on request outside active goes to active or fallback according to the low-power request pin.
// - a channel requested from outside active or fallback turns on only after the transition completes.
// - active is entered when the low-power pin is high and any input pin or channel-on bit is set.
// - with stay-active clear, active falls back to idle when all inputs and bits are zero; with it set active holds.
// - fallback is entered when the low-power pin is low and any input pin is high, driving that input's channel.
// - sleep is entered when the low-power pin is low and all input pins are low.
`timescale 1ns/1ps
module operation_mode_supply_gating
   import opmode_pkg::*;
(
   input  wire logic                    sys_clk_in,
   input  wire logic                    rst_n_in,
   input  wire logic                    clk_en_in,
   input  wire logic                    low_power_req_n_in,
   input  wire logic [NUM_INPUTS-1:0]   direct_input_pins_in,
   input  wire logic [NUM_CHANNELS-1:0] channel_on_bits_in,
   input  wire logic [NUM_CHANNELS-1:0] in0_map_in,
   input  wire logic [NUM_CHANNELS-1:0] in1_map_in,
   input  wire logic                    stay_active_bit_in,
   input  wire logic                    batt_uv_in,
   input  wire logic                    batt_op_in,
   input  wire logic                    logic_uv_in,
   input  wire logic                    logic_lop_in,
   output logic [NUM_CHANNELS-1:0]      channel_enable_out,
   output logic                         spi_reg_reset_out,
   output logic                         spi_enable_out,
   output logic                         spi_write_enable_out,
   output logic [1:0]                   spi_rate_limit_out,
   output logic [2:0]                   mode_out
);

   // ------------------------------------------------------------
   // input synchronisation
   // ------------------------------------------------------------
   // pins and supply flags all come from outside the clock domain
   logic [6:0] async_bus;
   logic [6:0] sync_bus;
   logic       lp_req_n;
   logic [1:0] pins;
   logic       batt_uv;
   logic       batt_op;
   logic       logic_uv;
   logic       logic_lop;

   assign async_bus = {low_power_req_n_in, direct_input_pins_in, batt_uv_in,
                       batt_op_in, logic_uv_in, logic_lop_in};

   sync2 #(
      .WIDTH (7)
   ) u_sync (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .clk_en_in  (clk_en_in),
      .async_in   (async_bus),
      .sync_out   (sync_bus)
   );

   assign lp_req_n  = sync_bus[6];
   assign pins      = sync_bus[5:4];
   assign batt_uv   = sync_bus[3];
   assign batt_op   = sync_bus[2];
   assign logic_uv  = sync_bus[1];
   assign logic_lop = sync_bus[0];

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic logic [NUM_CHANNELS-1:0] pin_channels(
      input logic [1:0]              p,
      input logic [NUM_CHANNELS-1:0] m0,
      input logic [NUM_CHANNELS-1:0] m1
   );
      logic [NUM_CHANNELS-1:0] r;
      r = CHANNELS_RESET;
      if (p[0]) begin
         r = r | m0;
      end
      if (p[1]) begin
         r = r | m1;
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // supply classification
   // ------------------------------------------------------------
   // logic_lop high means the logic supply is above low-operating level
   logic batt_dead;
   logic logic_ok;
   logic spi_alive;
   logic fb_ok;

   assign batt_dead = batt_uv;
   assign logic_ok  = !logic_uv;
   assign spi_alive = logic_ok;
   // fallback is never entered, not even briefly, with both supplies low
   assign fb_ok     = !(batt_dead && !logic_ok);

   // ------------------------------------------------------------
   // operating mode state machine
   // ------------------------------------------------------------
   op_mode_t                mode_r;
   op_mode_t                mode_nxt;
   logic [WAKE_CNT_W-1:0]   wake_cnt_r;
   logic                    any_pin;
   logic                    any_bit;
   logic                    spi_bits_valid;

   assign any_pin        = |pins;
   assign spi_bits_valid = logic_ok && (mode_r == MODE_IDLE || mode_r == MODE_ACTIVE ||
                                        mode_r == MODE_WAKE_ACTIVE);
   assign any_bit        = spi_bits_valid && (|channel_on_bits_in);

   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         MODE_SLEEP, MODE_IDLE: begin
            if (!lp_req_n) begin
               if (any_pin && fb_ok) begin
                  mode_nxt = MODE_WAKE_FALLBACK;
               end else if (!any_pin) begin
                  mode_nxt = MODE_SLEEP;
               end
            end else if (any_pin || any_bit) begin
               mode_nxt = MODE_WAKE_ACTIVE;
            end else begin
               mode_nxt = MODE_IDLE;
            end
         end
         MODE_WAKE_ACTIVE: begin
            if (!lp_req_n) begin
               mode_nxt = (any_pin && fb_ok) ? MODE_WAKE_FALLBACK : MODE_SLEEP;
            end else if (wake_cnt_r == '0) begin
               mode_nxt = MODE_ACTIVE;
            end
         end
         MODE_WAKE_FALLBACK: begin
            if (lp_req_n) begin
               mode_nxt = MODE_WAKE_ACTIVE;
            end else if (!any_pin || !fb_ok) begin
               mode_nxt = MODE_SLEEP;
            end else if (wake_cnt_r == '0) begin
               mode_nxt = MODE_FALLBACK;
            end
         end
         MODE_ACTIVE: begin
            if (!lp_req_n) begin
               mode_nxt = (any_pin && fb_ok) ? MODE_FALLBACK : MODE_SLEEP;
            end else if (!stay_active_bit_in && !any_pin && !any_bit) begin
               mode_nxt = MODE_IDLE;
            end
         end
         MODE_FALLBACK: begin
            if (!fb_ok) begin
               mode_nxt = MODE_SLEEP;
            end else if (lp_req_n) begin
               mode_nxt = (any_pin || any_bit) ? MODE_ACTIVE : MODE_IDLE;
            end else if (!any_pin) begin
               mode_nxt = MODE_SLEEP;
            end
         end
         default: begin
            mode_nxt = MODE_SLEEP;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_r <= MODE_SLEEP;
      end else if (clk_en_in) begin
         mode_r <= mode_nxt;
      end
   end

   // latency counter reloads on entry to a wake state
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wake_cnt_r <= '0;
      end else if (clk_en_in) begin
         if ((mode_nxt == MODE_WAKE_ACTIVE || mode_nxt == MODE_WAKE_FALLBACK) && mode_nxt != mode_r) begin
            wake_cnt_r <= WAKE_CNT_W'(WAKE_CYCLES - 1);
         end else if (wake_cnt_r != '0) begin
            wake_cnt_r <= wake_cnt_r - 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // channel gating
   // ------------------------------------------------------------
   logic [NUM_CHANNELS-1:0] chan_nxt;
   logic [NUM_CHANNELS-1:0] pin_map;
   logic [NUM_CHANNELS-1:0] pin_default;

   assign pin_map     = pin_channels(pins, in0_map_in, in1_map_in);
   assign pin_default = pin_channels(pins, IN0_DEFAULT_MAP, IN1_DEFAULT_MAP);

   always_comb begin
      chan_nxt = CHANNELS_RESET;
      if (batt_dead) begin
         chan_nxt = CHANNELS_RESET;
      end else if (mode_r == MODE_ACTIVE) begin
         if (logic_ok) begin
            chan_nxt = channel_on_bits_in | pin_map;
         end else begin
            chan_nxt = pin_default;
         end
      end else if (mode_r == MODE_FALLBACK) begin
         chan_nxt = pin_default;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         channel_enable_out <= CHANNELS_RESET;
      end else if (clk_en_in) begin
         channel_enable_out <= chan_nxt;
      end
   end

   // ------------------------------------------------------------
   // serial interface gating
   // ------------------------------------------------------------
   logic       regs_live;
   logic [1:0] rate_nxt;

   // sleep resets registers regardless of supplies
   assign regs_live = spi_alive && (mode_r != MODE_SLEEP);

   always_comb begin
      rate_nxt = SPI_RATE_NONE;
      if (regs_live) begin
         if (logic_lop || batt_op) begin
            rate_nxt = SPI_RATE_5MHZ;
         end else begin
            rate_nxt = SPI_RATE_1MHZ;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         spi_reg_reset_out    <= 1'b1;
         spi_enable_out       <= 1'b0;
         spi_write_enable_out <= 1'b0;
         spi_rate_limit_out   <= SPI_RATE_NONE;
      end else if (clk_en_in) begin
         spi_reg_reset_out    <= !regs_live;
         spi_enable_out       <= regs_live;
         // fallback makes registers read-only
         spi_write_enable_out <= regs_live && (mode_r != MODE_FALLBACK) && (mode_r != MODE_WAKE_FALLBACK);
         spi_rate_limit_out   <= rate_nxt;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_out <= 3'h0;
      end else if (clk_en_in) begin
         mode_out <= 3'(mode_nxt);
      end
   end

endmodule

// *** inc/opmode_pkg.sv ***
// Purpose: shared constants and types for the operation-mode controller
// Assumes: 50 MHz logic clock, eight channels, two direct input pins
// Notes:   transition latencies are plain defaults, tune per silicon
package opmode_pkg;
   localparam int unsigned NUM_CHANNELS      = 8;
   localparam int unsigned NUM_INPUTS        = 2;
   localparam int unsigned CLK_PERIOD_NS     = 20;
   // mode transition latency, time in ns and derived cycle count
   localparam int unsigned WAKE_TIME_NS      = 200;
   localparam int unsigned WAKE_CYCLES       = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WAKE_CNT_W        = 8;
   localparam logic [7:0]  CHANNELS_RESET    = 8'h00;
   localparam logic [7:0]  IN0_DEFAULT_MAP   = 8'h04;
   localparam logic [7:0]  IN1_DEFAULT_MAP   = 8'h08;
   localparam logic [1:0]  SPI_RATE_NONE     = 2'h0;
   localparam logic [1:0]  SPI_RATE_1MHZ     = 2'h1;
   localparam logic [1:0]  SPI_RATE_5MHZ     = 2'h2;

   typedef enum logic [2:0] {
      MODE_SLEEP,
      MODE_IDLE,
      MODE_WAKE_ACTIVE,
      MODE_ACTIVE,
      MODE_WAKE_FALLBACK,
      MODE_FALLBACK
   } op_mode_t;
endpackage

// *** design/sync2.sv ***
// Purpose: two-flop level synchroniser for a bus of asynchronous flags
// Assumes: inputs are quasi-static levels
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module sync2 #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             sys_clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             clk_en_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else if (clk_en_in) begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule

// *** test/host_model.sv ***
// Purpose: host side model driving the control pins and channel bits
// Assumes: bench calls put just after a falling edge
// Notes:   never clocks the serial port, so both rate caps hold
`timescale 1ns/1ps
module host_model
   import opmode_pkg::*;
(
   output logic                    lp_n_out,
   output logic [NUM_INPUTS-1:0]   pins_out,
   output logic [NUM_CHANNELS-1:0] bits_out,
   output logic                    stay_out
);
   // plain levels only; no serial clock at 1 MHz or 5 MHz is ever issued
   task automatic put(input logic lp, input logic [1:0] p, input logic [7:0] b, input logic s);
      lp_n_out = lp;
      pins_out = p;
      bits_out = b;
      stay_out = s;
   endtask
   initial begin
      put(1'b1, 2'h0, 8'h00, 1'b0);
   end
endmodule

// *** test/operation_mode_supply_gating_checker.sv ***
// Purpose: assertions on mode and supply gating outputs
// Assumes: clk_en_in held high by the bench
// Notes:   repetitions of four or five cover the two-flop input sync
`timescale 1ns/1ps
module operation_mode_supply_gating_checker
   import opmode_pkg::*;
(
   input wire logic                    sys_clk_in,
   input wire logic                    rst_n_in,
   input wire logic                    low_power_req_n_in,
   input wire logic [NUM_INPUTS-1:0]   direct_input_pins_in,
   input wire logic [NUM_CHANNELS-1:0] channel_on_bits_in,
   input wire logic                    stay_active_bit_in,
   input wire logic                    batt_uv_in,
   input wire logic                    batt_op_in,
   input wire logic                    logic_uv_in,
   input wire logic                    logic_lop_in,
   input wire logic [NUM_CHANNELS-1:0] channel_enable_out,
   input wire logic                    spi_reg_reset_out,
   input wire logic                    spi_enable_out,
   input wire logic [1:0]              spi_rate_limit_out,
   input wire logic [2:0]              mode_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   chan_uv_off_a: assert property (batt_uv_in[*5] |-> channel_enable_out == 8'h00)
      else $error("channel on under battery undervoltage");
   spi_uv_reset_a: assert property (logic_uv_in[*5] |-> spi_reg_reset_out && !spi_enable_out
      && spi_rate_limit_out == SPI_RATE_NONE) else $error("serial alive under logic undervoltage");
   rate_slow_a: assert property ((!logic_uv_in && !logic_lop_in && !batt_op_in && low_power_req_n_in)[*5]
      |-> spi_rate_limit_out == SPI_RATE_1MHZ) else $error("slow rate cap wrong");
   rate_fast_a: assert property ((!logic_uv_in && (logic_lop_in || batt_op_in) && low_power_req_n_in)[*5]
      |-> spi_rate_limit_out == SPI_RATE_5MHZ) else $error("fast rate cap wrong");
   fb_blocked_a: assert property ((batt_uv_in && logic_uv_in)[*5] |-> mode_out != MODE_FALLBACK)
      else $error("fallback reached with both supplies low");
   wake_bound_a: assert property (mode_out == MODE_WAKE_ACTIVE |-> ##[1:12] mode_out != MODE_WAKE_ACTIVE)
      else $error("wake to active too long");
   wake_dark_a: assert property ($past(mode_out) == mode_out
      && mode_out inside {MODE_WAKE_ACTIVE, MODE_WAKE_FALLBACK} |-> channel_enable_out == 8'h00)
      else $error("channel on before wake ends");
   idle_return_a: assert property (mode_out == MODE_ACTIVE && !stay_active_bit_in
      && channel_on_bits_in == 8'h00 && direct_input_pins_in == 2'h0 && $past(direct_input_pins_in) == 2'h0
      && $past(direct_input_pins_in, 2) == 2'h0 && low_power_req_n_in && $past(low_power_req_n_in, 2)
      |=> mode_out == MODE_IDLE) else $error("no return to idle");
   fb_default_a: assert property ($past(mode_out) == MODE_FALLBACK && mode_out == MODE_FALLBACK
      |-> (channel_enable_out & 8'hF3) == 8'h00) else $error("fallback drives other channel");
   sleep_entry_a: assert property ((!low_power_req_n_in && direct_input_pins_in == 2'h0)[*4]
      |=> mode_out == MODE_SLEEP) else $error("no sleep entry");
endmodule
bind operation_mode_supply_gating operation_mode_supply_gating_checker chk_i (.sys_clk_in, .rst_n_in,
   .low_power_req_n_in, .direct_input_pins_in, .channel_on_bits_in, .stay_active_bit_in, .batt_uv_in,
   .batt_op_in, .logic_uv_in, .logic_lop_in, .channel_enable_out, .spi_reg_reset_out, .spi_enable_out,
   .spi_rate_limit_out, .mode_out);

// *** test/operation_mode_supply_gating_tb.sv ***
// Purpose: self-checking bench for the mode controller
// Assumes: supply flags driven by the bench, pins by the host model
// Notes:   clk_en and the input maps are tied to run and defaults
`timescale 1ns/1ps
module operation_mode_supply_gating_tb;
   import opmode_pkg::*;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       bu = 1'b0, bo = 1'b1, lu = 1'b0, ll = 1'b1;
   logic       lp_n, stay, s_rst, s_en, s_wr;
   logic [1:0] pins, rate;
   logic [7:0] bits, chan;
   logic [2:0] mode;
   int         mismatches = 0;
   int         checks_done = 0;
   always #10 clk = ~clk;
   host_model host (.lp_n_out(lp_n), .pins_out(pins), .bits_out(bits), .stay_out(stay));
   operation_mode_supply_gating dut (.sys_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(1'b1),
      .low_power_req_n_in(lp_n), .direct_input_pins_in(pins), .channel_on_bits_in(bits),
      .in0_map_in(IN0_DEFAULT_MAP), .in1_map_in(IN1_DEFAULT_MAP), .stay_active_bit_in(stay),
      .batt_uv_in(bu), .batt_op_in(bo), .logic_uv_in(lu), .logic_lop_in(ll), .channel_enable_out(chan),
      .spi_reg_reset_out(s_rst), .spi_enable_out(s_en), .spi_write_enable_out(s_wr),
      .spi_rate_limit_out(rate), .mode_out(mode));
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cm(input logic [2:0] m);
      chk("mode", {5'h0, mode}, {5'h0, m});
   endtask
   // bounded so a stuck mode shows as a mismatch, not a hang
   task automatic wait_mode(input logic [2:0] m);
      for (int n = 0; n < 40 && mode !== m; n++) @(negedge clk);
      cm(m);
   endtask
   task automatic sup(input logic a, input logic b, input logic c, input logic d);
      {bu, bo, lu, ll} = {a, b, c, d};
      repeat (4) @(negedge clk);
   endtask
   task automatic t_wake();
      host.put(1'b1, 2'h0, 8'h01, 1'b0);
      @(negedge clk);
      cm(MODE_WAKE_ACTIVE);
      chk("chan", chan, 8'h00);
      wait_mode(MODE_ACTIVE);
      @(negedge clk);
      chk("chan", chan, 8'h01);
      chk("wr", {7'h0, s_wr}, 8'h01);
      host.put(1'b1, 2'h0, 8'h00, 1'b0);
      @(negedge clk);
      cm(MODE_IDLE);
      $display("test wake done");
   endtask
   task automatic t_stay();
      host.put(1'b1, 2'h0, 8'h80, 1'b1);
      wait_mode(MODE_ACTIVE);
      host.put(1'b1, 2'h0, 8'h00, 1'b1);
      repeat (5) @(negedge clk);
      cm(MODE_ACTIVE);
      host.put(1'b1, 2'h0, 8'h00, 1'b0);
      @(negedge clk);
      cm(MODE_IDLE);
      $display("test stay done");
   endtask
   task automatic t_pin();
      host.put(1'b1, 2'h1, 8'h00, 1'b0);
      wait_mode(MODE_ACTIVE);
      @(negedge clk);
      chk("chan", chan, 8'h04);
      host.put(1'b0, 2'h1, 8'h00, 1'b0);
      wait_mode(MODE_FALLBACK);
      host.put(1'b1, 2'h1, 8'h00, 1'b0);
      wait_mode(MODE_ACTIVE);
      host.put(1'b1, 2'h0, 8'h00, 1'b0);
      wait_mode(MODE_IDLE);
      $display("test pin done");
   endtask
   task automatic t_fallback();
      host.put(1'b0, 2'h1, 8'h00, 1'b0);
      wait_mode(MODE_FALLBACK);
      @(negedge clk);
      chk("chan", chan, 8'h04);
      host.put(1'b0, 2'h2, 8'h00, 1'b0);
      repeat (4) @(negedge clk);
      chk("chan", chan, 8'h08);
      host.put(1'b0, 2'h0, 8'h00, 1'b0);
      wait_mode(MODE_SLEEP);
      @(negedge clk);
      chk("rst", {7'h0, s_rst}, 8'h01);
      $display("test fallback done");
   endtask
   task automatic t_supply();
      host.put(1'b1, 2'h0, 8'h00, 1'b0);
      sup(1'b0, 1'b0, 1'b0, 1'b0);
      chk("rate", {6'h0, rate}, {6'h0, SPI_RATE_1MHZ});
      sup(1'b0, 1'b1, 1'b0, 1'b0);
      chk("rate", {6'h0, rate}, {6'h0, SPI_RATE_5MHZ});
      sup(1'b0, 1'b1, 1'b1, 1'b0);
      chk("spi", {6'h0, s_rst, s_en}, 8'h02);
      host.put(1'b1, 2'h0, 8'hFF, 1'b0);
      repeat (4) @(negedge clk);
      chk("chan", chan, 8'h00);
      host.put(1'b0, 2'h1, 8'hFF, 1'b0);
      wait_mode(MODE_FALLBACK);
      @(negedge clk);
      chk("chan", chan, 8'h04);
      sup(1'b1, 1'b0, 1'b0, 1'b1);
      chk("chan", chan, 8'h00);
      sup(1'b1, 1'b0, 1'b1, 1'b0);
      chk("fb", {7'h0, mode === MODE_FALLBACK}, 8'h00);
      sup(1'b0, 1'b1, 1'b0, 1'b1);
      $display("test supply done");
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      mismatches++;
      test_done();
   end
   initial begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      repeat (5) @(negedge clk);
      t_wake();
      t_stay();
      t_pin();
      t_fallback();
      t_supply();
      test_done();
   end
endmodule
